// >>> logic/mcs_top.sv
// Main clock source select, prescaler and guarded configuration registers
// Overview of operation
// - Reset loads center frequency choice and its factory trims from fuses.
// - Four factory frequency errors readable as signed bytes.
// - Errors are 8-bit compressed Q1.10, MSB sign, seven low bits.
// - Slow oscillator supplies a 1 kHz tick to counter, watchdog, brown-out.
// - Slow clock delivered only after analog start and four cycles.
// - Pin is configured as clock input whenever pin clock is requested.
// - Pin clock available after a two-cycle start and four rising edges.
// - Guard key then protected write within four instructions.
// - Unguarded protected writes are accepted but change nothing.
// - Guard covers both main controls, lock, fast control, trims, slow control.
// - Source select 0 fast, 1 slow, 3 pin, 2 reserved.
// - Ratio codes 0-5 give 2..64; 8..C give 6,10,12,24,48.
// - Ratio may be changed while running.
// - Prescaler off passes main clock undivided.
// - Settings lock resets from the fuse calibration-lock bit.
// - Lock set blocks main controls, lock and active trims until reset.
// - Switching flag reads 1 while a source change waits for stability.
// - Pin switch waits for edges; no other source change accepted meanwhile.
// - Keep-running holds oscillator warm; reopen after four cycles.
`timescale 1ns/1ns
`include "mcs_regs.svh"
module mcs_top
  import mcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        guard_wr,
  input  wire logic [7:0]  guard_wdata,
  input  wire logic        insn_done,
  input  wire logic        center_freq_fuse,
  input  wire logic        fuse_cal_lock,
  input  wire logic [5:0]  freq_trim_16,
  input  wire logic [5:0]  freq_trim_20,
  input  wire logic [3:0]  temp_trim_16,
  input  wire logic [3:0]  temp_trim_20,
  input  wire logic [31:0] freq_err_fuse,
  input  wire logic        fast_analog_ok,
  input  wire logic        slow_analog_ok,
  input  wire logic        fast_osc_en,
  input  wire logic        slow_osc_en,
  input  wire logic        pin_clk_en,
  input  wire logic        periph_pin_req,
  input  wire logic        periph_slow_req,
  output logic             pin_as_clock,
  output logic             fast_osc_req,
  output logic             slow_osc_req,
  output logic             main_en,
  output logic             per_en,
  output logic             tick_1k,
  output logic             fast_center_sel,
  output logic      [5:0]  fast_freq_trim,
  output logic      [3:0]  fast_temp_trim
);
  typedef struct packed {
    logic [2:0]  guard_cnt;
    logic        ld_done;
    logic        center;
    logic        fuse_lock;
    logic [1:0]  src;
    logic [1:0]  active;
    logic        pre_on;
    logic [3:0]  ratio;
    logic        lock;
    logic        fast_keep;
    logic        slow_keep;
    logic [5:0]  ftrim;
    logic [3:0]  ttrim;
    mcs_sw_e     sw;
    logic [2:0]  pin_cnt;
    logic [2:0]  pin_edges;
    logic        pin_seen;
    logic        pin_prev;
    logic        slow_prev;
    logic        fast_prev;
    logic [15:0] tick_cnt;
    logic        tick;
    logic [7:0]  rdata;
    logic        main_pulse;
  } mcs_top_s;
  mcs_top_s st_reg, st_next;
  logic       fast_ready;
  logic       slow_ready;
  logic       guard_ok;
  logic       wr_ok;
  logic       src_ok;
  logic [7:0] status;
  logic       pin_req;
  logic [7:0] err_byte;

  assign pin_req = periph_pin_req || st_reg.src == MCS_SRC_PIN || st_reg.active == MCS_SRC_PIN;

  mcs_osc_gate u_fast (
    .clk          (clk),
    .nrst         (nrst),
    .request      (st_reg.src == MCS_SRC_FAST || st_reg.active == MCS_SRC_FAST),
    .keep_running (st_reg.fast_keep),
    .analog_ok    (fast_analog_ok),
    .settle       (`MCS_SETTLE_CYCLES),
    .ready        (fast_ready)
  );

  mcs_osc_gate u_slow (
    .clk          (clk),
    .nrst         (nrst),
    .request      (1'b1),
    .keep_running (st_reg.slow_keep),
    .analog_ok    (slow_analog_ok),
    .settle       (`MCS_SETTLE_CYCLES),
    .ready        (slow_ready)
  );

  mcs_clk_div u_div (
    .clk     (clk),
    .nrst    (nrst),
    .main_en (st_reg.main_pulse),
    .on      (st_reg.pre_on),
    .ratio   (st_reg.ratio),
    .per_en  (per_en)
  );

  always_comb begin
    status = 8'h00;
    status[`MCS_STAT_SWITCH_BIT] = st_reg.sw != MCS_IDLE;
    status[`MCS_STAT_FAST_BIT]   = fast_ready;
    status[`MCS_STAT_SLOW_BIT]   = slow_ready;
    status[`MCS_STAT_PIN_BIT]    = st_reg.pin_seen;
    unique case (reg_addr[1:0])
      2'h0: err_byte = freq_err_fuse[7:0];
      2'h1: err_byte = freq_err_fuse[15:8];
      2'h2: err_byte = freq_err_fuse[23:16];
      default: err_byte = freq_err_fuse[31:24];
    endcase
  end

  assign guard_ok = st_reg.guard_cnt != 3'h0;
  assign wr_ok    = reg_wr && guard_ok && st_reg.ld_done;

  always_comb begin
    st_next = st_reg;
    st_next.main_pulse = 1'b0;
    st_next.tick = 1'b0;
    // Fuse values caught one cycle after reset release
    if (!st_reg.ld_done) begin
      st_next.ld_done   = 1'b1;
      st_next.center    = center_freq_fuse;
      st_next.fuse_lock = fuse_cal_lock;
      st_next.lock      = fuse_cal_lock;
      st_next.ftrim     = center_freq_fuse ? freq_trim_20 : freq_trim_16;
      st_next.ttrim     = center_freq_fuse ? temp_trim_20 : temp_trim_16;
    end
    if (guard_wr && guard_wdata == `MCS_GUARD_KEY) begin
      st_next.guard_cnt = `MCS_GUARD_WINDOW;
    end else if (reg_wr && guard_ok) begin
      st_next.guard_cnt = 3'h0;
    end else if (insn_done && guard_ok) begin
      st_next.guard_cnt = st_reg.guard_cnt - 3'h1;
    end
    src_ok = st_reg.sw == MCS_IDLE || st_reg.src != MCS_SRC_PIN;
    if (wr_ok) begin
      unique case (reg_addr)
        `MCS_OFS_SRC_CTRL: begin
          if (!st_reg.lock && src_ok && reg_wdata[1:0] != MCS_SRC_RSVD) begin
            st_next.src = reg_wdata[1:0];
          end
        end
        `MCS_OFS_PRE_CTRL: begin
          if (!st_reg.lock) begin
            st_next.pre_on = reg_wdata[0];
            st_next.ratio  = reg_wdata[4:1];
          end
        end
        `MCS_OFS_LOCK: begin
          if (!st_reg.lock) begin
            st_next.lock = reg_wdata[0];
          end
        end
        `MCS_OFS_FAST_CTRL: st_next.fast_keep = reg_wdata[`MCS_RUN_SLEEP_BIT];
        `MCS_OFS_FAST_FTRIM: begin
          if (!st_reg.fuse_lock && !(st_reg.lock && st_reg.active == MCS_SRC_FAST)) begin
            st_next.ftrim = reg_wdata[`MCS_FTRIM_MSB:0];
          end
        end
        `MCS_OFS_FAST_TTRIM: begin
          if (!st_reg.fuse_lock && !(st_reg.lock && st_reg.active == MCS_SRC_FAST)) begin
            st_next.ttrim = reg_wdata[`MCS_TTRIM_MSB:0];
          end
        end
        `MCS_OFS_SLOW_CTRL: st_next.slow_keep = reg_wdata[`MCS_RUN_SLEEP_BIT];
        default: ;
      endcase
    end
    // Switch control: old source runs until new one is proven stable
    unique case (st_reg.sw)
      MCS_IDLE: begin
        if (st_reg.src != st_reg.active) begin
          st_next.sw = MCS_WAIT_STABLE;
        end
      end
      MCS_WAIT_STABLE: begin
        if ((st_reg.src == MCS_SRC_FAST && fast_ready) ||
            (st_reg.src == MCS_SRC_SLOW && slow_ready) ||
            (st_reg.src == MCS_SRC_PIN && st_reg.pin_seen)) begin
          st_next.sw = MCS_HANDOVER;
        end
      end
      MCS_HANDOVER: begin
        st_next.active = st_reg.src;
        st_next.sw = MCS_IDLE;
      end
    endcase
    // Pin clock: two-cycle start then edge counting
    if (!pin_req) begin
      st_next.pin_cnt = 3'h0;
    end else if (st_reg.pin_cnt != `MCS_PIN_START_CYCLES) begin
      st_next.pin_cnt = st_reg.pin_cnt + 3'h1;
    end
    st_next.pin_prev = pin_clk_en;
    if (st_reg.pin_cnt == `MCS_PIN_START_CYCLES && pin_clk_en && !st_reg.pin_prev &&
        !st_reg.pin_seen) begin
      if (st_reg.pin_edges == `MCS_PIN_EDGES - 3'h1) begin
        st_next.pin_seen = 1'b1;
      end else begin
        st_next.pin_edges = st_reg.pin_edges + 3'h1;
      end
    end
    // Main enable follows only the active source; whole source pulses only
    st_next.fast_prev = fast_osc_en;
    unique case (st_reg.active)
      MCS_SRC_FAST: st_next.main_pulse = fast_osc_en && !st_reg.fast_prev && fast_ready;
      MCS_SRC_SLOW: st_next.main_pulse = slow_osc_en && !st_reg.slow_prev && slow_ready;
      MCS_SRC_PIN:  st_next.main_pulse = pin_clk_en && !st_reg.pin_prev && st_reg.pin_seen;
      default:      st_next.main_pulse = 1'b0;
    endcase
    // Handover may meet two edges in a row; keep a gap so no short main cycle
    if (st_reg.main_pulse) begin
      st_next.main_pulse = 1'b0;
    end
    // 1 kHz tick from slow oscillator edges
    st_next.slow_prev = slow_osc_en;
    if (slow_ready && slow_osc_en && !st_reg.slow_prev) begin
      if (st_reg.tick_cnt == `MCS_TICK_HALF * 16'd4 - 16'd1) begin
        st_next.tick_cnt = 16'h0;
        st_next.tick = 1'b1;
      end else begin
        st_next.tick_cnt = st_reg.tick_cnt + 16'h1;
      end
    end
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `MCS_OFS_SRC_CTRL:   st_next.rdata = {6'h00, st_reg.src};
        `MCS_OFS_PRE_CTRL:   st_next.rdata = {3'h0, st_reg.ratio, st_reg.pre_on};
        `MCS_OFS_LOCK:       st_next.rdata = {7'h00, st_reg.lock};
        `MCS_OFS_STATUS:     st_next.rdata = status;
        `MCS_OFS_FAST_CTRL:  st_next.rdata = {6'h00, st_reg.fast_keep, 1'b0};
        `MCS_OFS_FAST_FTRIM: st_next.rdata = {2'h0, st_reg.ftrim};
        `MCS_OFS_FAST_TTRIM: st_next.rdata = {st_reg.fuse_lock, 3'h0, st_reg.ttrim};
        `MCS_OFS_SLOW_CTRL:  st_next.rdata = {6'h00, st_reg.slow_keep, 1'b0};
        default: begin
          if (reg_addr[4:2] == 3'(`MCS_OFS_ERR_BASE >> 2)) begin
            st_next.rdata = err_byte;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg        <= '0;
      st_reg.pre_on <= 1'(`MCS_RST_PRE_CTRL & 8'h01);
      st_reg.ratio  <= 4'(`MCS_RST_PRE_CTRL >> 1);
      st_reg.sw     <= MCS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata       <= 8'h00;
      pin_as_clock    <= 1'b0;
      fast_osc_req    <= 1'b0;
      slow_osc_req    <= 1'b0;
      main_en         <= 1'b0;
      tick_1k         <= 1'b0;
      fast_center_sel <= 1'b0;
      fast_freq_trim  <= 6'h00;
      fast_temp_trim  <= 4'h0;
    end else begin
      reg_rdata       <= st_next.rdata;
      pin_as_clock    <= pin_req;
      fast_osc_req    <= st_reg.src == MCS_SRC_FAST || st_reg.active == MCS_SRC_FAST ||
                         st_reg.fast_keep;
      slow_osc_req    <= 1'b1;
      main_en         <= st_next.main_pulse;
      tick_1k         <= st_next.tick;
      fast_center_sel <= st_next.center;
      fast_freq_trim  <= st_next.ftrim;
      fast_temp_trim  <= st_next.ttrim;
    end
  end
endmodule // mcs_top

// >>> logic/mcs_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
`define MCS_OFS_SRC_CTRL     5'h00
`define MCS_OFS_PRE_CTRL     5'h01
`define MCS_OFS_LOCK         5'h02
`define MCS_OFS_STATUS       5'h03
`define MCS_OFS_FAST_CTRL    5'h10
`define MCS_OFS_FAST_FTRIM   5'h11
`define MCS_OFS_FAST_TTRIM   5'h12
`define MCS_OFS_SLOW_CTRL    5'h18
`define MCS_OFS_ERR_BASE     5'h1C
`define MCS_RST_SRC_CTRL     8'h00
`define MCS_RST_PRE_CTRL     8'h11
`define MCS_GUARD_KEY        8'hD8
`define MCS_GUARD_WINDOW     3'h4
`define MCS_SETTLE_CYCLES    3'h4
`define MCS_PIN_START_CYCLES 3'h2
`define MCS_PIN_EDGES        3'h4
`define MCS_STAT_SWITCH_BIT  0
`define MCS_STAT_FAST_BIT    4
`define MCS_STAT_SLOW_BIT    5
`define MCS_STAT_PIN_BIT     7
`define MCS_RUN_SLEEP_BIT    1
`define MCS_FTRIM_MSB        5
`define MCS_TTRIM_MSB        3
`define MCS_TTRIM_LOCK_BIT   7
`define MCS_TICK_HALF        16'd4
`endif

// >>> logic/mcs_pkg.sv
// Types shared by the clock select and prescale block
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_SRC_FAST = 2'h0,
    MCS_SRC_SLOW = 2'h1,
    MCS_SRC_RSVD = 2'h2,
    MCS_SRC_PIN  = 2'h3
  } mcs_src_e;
  typedef enum {MCS_IDLE, MCS_WAIT_STABLE, MCS_HANDOVER} mcs_sw_e;
endpackage

// >>> logic/mcs_osc_gate.sv
// Oscillator start-up gate: ready after analog start plus a cycle count
`timescale 1ns/1ns
`include "mcs_regs.svh"
module mcs_osc_gate
  import mcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       request,
  input  wire logic       keep_running,
  input  wire logic       analog_ok,
  input  wire logic [2:0] settle,
  output logic            ready
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       rdy;
    logic       warm;
  } mcs_gate_s;
  mcs_gate_s st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.warm = keep_running ? (st_reg.warm | analog_ok) : 1'b0;
    if (!request) begin
      st_next.cnt = 3'h0;
      st_next.rdy = 1'b0;
    end else if (!st_reg.rdy && (analog_ok || st_reg.warm)) begin
      // Warm oscillator skips analog start
      if (st_reg.cnt == settle - 3'h1) begin
        st_next.rdy = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign ready = st_reg.rdy;
endmodule // mcs_osc_gate

// >>> logic/mcs_clk_div.sv
// Prescaler producing one-cycle enable pulses for the peripheral clock
`timescale 1ns/1ns
`include "mcs_regs.svh"
module mcs_clk_div
  import mcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       main_en,
  input  wire logic       on,
  input  wire logic [3:0] ratio,
  output logic            per_en
);
  typedef struct packed {
    logic [6:0] cnt;
    logic [6:0] div;
    logic       pulse;
  } mcs_div_s;
  mcs_div_s st_reg, st_next;
  logic [6:0] div_sel;
  always_comb begin
    unique case (ratio)
      4'h0: div_sel = 7'd2;
      4'h1: div_sel = 7'd4;
      4'h2: div_sel = 7'd8;
      4'h3: div_sel = 7'd16;
      4'h4: div_sel = 7'd32;
      4'h5: div_sel = 7'd64;
      4'h8: div_sel = 7'd6;
      4'h9: div_sel = 7'd10;
      4'hA: div_sel = 7'd12;
      4'hB: div_sel = 7'd24;
      4'hC: div_sel = 7'd48;
      default: div_sel = 7'd2;
    endcase
  end
  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    if (!on) begin
      st_next.pulse = main_en;
      st_next.cnt = 7'h0;
      st_next.div = div_sel;
    end else if (main_en) begin
      // New ratio taken only at period end, so no short pulse
      if (st_reg.cnt >= st_reg.div - 7'h1) begin
        st_next.cnt = 7'h0;
        st_next.pulse = 1'b1;
        st_next.div = div_sel;
      end else begin
        st_next.cnt = st_reg.cnt + 7'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '{cnt: 7'h0, div: 7'd6, pulse: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
  assign per_en = st_reg.pulse;
endmodule // mcs_clk_div

// >>> testbench/mcs_assertions.sv
// Concurrent checks on the ports of the clock select and prescale top
`timescale 1ns/1ns
module mcs_assertions
  import mcs_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       periph_pin_req,
  input wire logic       pin_as_clock,
  input wire logic       slow_osc_req,
  input wire logic       main_en,
  input wire logic       per_en,
  input wire logic       tick_1k,
  input wire logic       fast_center_sel,
  input wire logic [5:0] fast_freq_trim,
  input wire logic [3:0] fast_temp_trim
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_pin_config: assert property ($rose(periph_pin_req) |-> ##[0:3] pin_as_clock)
    else $error("pin not turned into clock input");
  a_pin_hold: assert property (periph_pin_req && pin_as_clock |=> pin_as_clock)
    else $error("pin clock input dropped while requested");
  a_main_pulse: assert property (main_en |=> !main_en)
    else $error("main enable longer than one cycle");
  // Peripheral pulses must sit on the main clock grid, never between
  a_per_follow: assert property (per_en |-> $past(main_en))
    else $error("peripheral pulse without main pulse");
  a_tick_space: assert property (tick_1k |=> !tick_1k [*8])
    else $error("slow tick pulses too close");
  a_tick_slow: assert property (tick_1k |-> slow_osc_req)
    else $error("slow tick without slow oscillator request");
  a_center_fixed: assert property ($past(nrst, 3) |-> $stable(fast_center_sel))
    else $error("center frequency choice moved after reset");
  a_trim_hold: assert property ($past(nrst, 3) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(fast_freq_trim))
    else $error("frequency trim moved without a write");
  a_temp_hold: assert property ($past(nrst, 3) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(fast_temp_trim))
    else $error("temperature trim moved without a write");
endmodule // mcs_assertions

// >>> testbench/test_mcs_top.sv
// Self-checking bench for the clock select and prescale top
`timescale 1ns/1ns
`include "mcs_regs.svh"
module test_mcs_top
  import mcs_pkg::*;
;
  typedef struct {logic [7:0] d; int div;} mcs_row_s;
  logic        clk              = 1'b0;
  logic        nrst             = 1'b0;
  logic [4:0]  reg_addr         = 5'h00;
  logic        reg_wr           = 1'b0;
  logic        reg_rd           = 1'b0;
  logic [7:0]  reg_wdata        = 8'h00;
  logic        guard_wr         = 1'b0;
  logic [7:0]  guard_wdata      = 8'h00;
  logic        insn_done        = 1'b0;
  logic        center_freq_fuse = 1'b1;
  logic        fuse_cal_lock    = 1'b0;
  logic [5:0]  freq_trim_16     = 6'h15;
  logic [5:0]  freq_trim_20     = 6'h2A;
  logic [3:0]  temp_trim_16     = 4'h5;
  logic [3:0]  temp_trim_20     = 4'hA;
  logic [31:0] freq_err_fuse    = 32'h807FC305;
  logic        fast_analog_ok   = 1'b0;
  logic        slow_analog_ok   = 1'b0;
  logic        fast_osc_en      = 1'b0;
  logic        slow_osc_en      = 1'b0;
  logic        pin_clk_en       = 1'b0;
  logic        periph_pin_req   = 1'b0;
  logic        periph_slow_req  = 1'b0;
  logic [7:0]  reg_rdata;
  logic        pin_as_clock;
  logic        fast_osc_req;
  logic        slow_osc_req;
  logic        main_en;
  logic        per_en;
  logic        tick_1k;
  logic        fast_center_sel;
  logic [5:0]  fast_freq_trim;
  logic [3:0]  fast_temp_trim;
  int          n_mismatch       = 0;
  int          total_checks     = 0;
  int          ph               = 0;
  // Ratios keep the peripheral rate legal for every source used
  mcs_row_s    rows [12]        = '{'{8'h01, 2}, '{8'h03, 4}, '{8'h05, 8}, '{8'h07, 16},
    '{8'h09, 32}, '{8'h0B, 64}, '{8'h11, 6}, '{8'h13, 10}, '{8'h15, 12}, '{8'h17, 24},
    '{8'h19, 48}, '{8'h00, 1}};
  logic [7:0]  srcs [3]         = '{8'h01, 8'h03, 8'h00};
  int          mper [3]         = '{8, 4, 2};

  mcs_top mcs_top_i (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .guard_wr(guard_wr),
    .guard_wdata(guard_wdata), .insn_done(insn_done), .center_freq_fuse(center_freq_fuse),
    .fuse_cal_lock(fuse_cal_lock), .freq_trim_16(freq_trim_16), .freq_trim_20(freq_trim_20),
    .temp_trim_16(temp_trim_16), .temp_trim_20(temp_trim_20), .freq_err_fuse(freq_err_fuse),
    .fast_analog_ok(fast_analog_ok), .slow_analog_ok(slow_analog_ok),
    .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en), .pin_clk_en(pin_clk_en),
    .periph_pin_req(periph_pin_req), .periph_slow_req(periph_slow_req),
    .pin_as_clock(pin_as_clock), .fast_osc_req(fast_osc_req), .slow_osc_req(slow_osc_req),
    .main_en(main_en), .per_en(per_en), .tick_1k(tick_1k), .fast_center_sel(fast_center_sel),
    .fast_freq_trim(fast_freq_trim), .fast_temp_trim(fast_temp_trim)
  );

  always #2 clk = ~clk;
  // Fast osc rises every 2 cycles, pin every 4, slow every 8
  always @(negedge clk) begin
    ph <= ph + 1;
    fast_osc_en <= ~fast_osc_en;
    if (ph % 2 == 1) pin_clk_en <= ~pin_clk_en;
    if (ph % 4 == 3) slow_osc_en <= ~slow_osc_en;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang;
    $display("unexpected at %0t: wait ran out", $time);
    n_mismatch++;
    test_done();
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Trailing idle cycle keeps a strobe from toggling twice in one step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic key(input int n);
    guard_wdata = `MCS_GUARD_KEY;
    guard_wr = 1'b1;
    cyc(1);
    guard_wr = 1'b0;
    repeat (n) begin
      insn_done = 1'b1;
      cyc(1);
      insn_done = 1'b0;
      cyc(1);
    end
  endtask
  task automatic gwr(input logic [4:0] a, input logic [7:0] d);
    key(0);
    wr(a, d);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    v = reg_rdata;
    cyc(1);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk8(v, exp);
  endtask
  task automatic period(input bit sel, output int n);
    int k;
    k = 0;
    n = 1;
    while ((sel ? tick_1k : per_en) !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    cyc(1);
    while ((sel ? tick_1k : per_en) !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
      n++;
    end
    if (k >= 3000) hang();
  endtask
  task automatic settle;
    logic [7:0] v;
    int k;
    for (k = 0; k < 200; k++) begin
      rd(`MCS_OFS_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    if (k >= 200) hang();
  endtask
  task automatic rst(input logic cen, input logic lk);
    nrst = 1'b0;
    fast_analog_ok = 1'b0;
    slow_analog_ok = 1'b0;
    center_freq_fuse = cen;
    fuse_cal_lock = lk;
    cyc(20);
    nrst = 1'b1;
    cyc(2);
    fast_analog_ok = 1'b1;
    slow_analog_ok = 1'b1;
  endtask

  initial begin
    logic [7:0] v;
    int n;
    int i;
    @(negedge clk);
    rst(1'b1, 1'b0);
    rdc(`MCS_OFS_SRC_CTRL, 8'h00);
    rdc(`MCS_OFS_LOCK, 8'h00);
    rdc(`MCS_OFS_FAST_FTRIM, {2'h0, freq_trim_20});
    rdc(`MCS_OFS_FAST_TTRIM, {4'h0, temp_trim_20});
    chk8({7'h00, fast_center_sel}, 8'h01);
    chk8({4'h0, fast_temp_trim}, {4'h0, temp_trim_20});
    chk8({7'h00, slow_osc_req}, 8'h01);
    for (i = 0; i < 4; i++) begin
      rdc(`MCS_OFS_ERR_BASE + 5'(i), freq_err_fuse[8*i +: 8]);
    end
    rdc(`MCS_OFS_PRE_CTRL, 8'h11);
    period(0, n);
    chkn(n, 12);
    for (i = 0; i < 12; i++) begin
      gwr(`MCS_OFS_PRE_CTRL, rows[i].d);
      rdc(`MCS_OFS_PRE_CTRL, rows[i].d);
      period(0, n);
      period(0, n);
      chkn(n, 2 * rows[i].div);
    end
    wr(`MCS_OFS_PRE_CTRL, 8'h05);
    rdc(`MCS_OFS_PRE_CTRL, 8'h00);
    key(3);
    wr(`MCS_OFS_PRE_CTRL, 8'h03);
    rdc(`MCS_OFS_PRE_CTRL, 8'h03);
    key(4);
    wr(`MCS_OFS_PRE_CTRL, 8'h00);
    rdc(`MCS_OFS_PRE_CTRL, 8'h03);
    gwr(`MCS_OFS_PRE_CTRL, 8'h00);
    // Pin not yet requested, so its switch stays pending long enough to test
    for (i = 0; i < 3; i++) begin
      gwr(`MCS_OFS_SRC_CTRL, srcs[i]);
      if (i > 0) begin
        rd(`MCS_OFS_STATUS, v);
        chk8({7'h00, v[0]}, 8'h01);
      end
      if (i == 1) gwr(`MCS_OFS_SRC_CTRL, 8'h00);
      settle();
      rdc(`MCS_OFS_SRC_CTRL, srcs[i]);
      period(0, n);
      chkn(n, mper[i]);
      if (i == 0) begin
        gwr(`MCS_OFS_SRC_CTRL, 8'h02);
        rdc(`MCS_OFS_SRC_CTRL, 8'h01);
      end
    end
    chk8({7'h00, pin_as_clock}, 8'h00);
    periph_pin_req = 1'b1;
    periph_slow_req = 1'b1;
    cyc(4);
    chk8({7'h00, pin_as_clock}, 8'h01);
    period(1, n);
    chkn(n, 128);
    // Warm fast oscillator must reopen without its analog start
    gwr(`MCS_OFS_FAST_CTRL, 8'h02);
    rdc(`MCS_OFS_FAST_CTRL, 8'h02);
    gwr(`MCS_OFS_SRC_CTRL, 8'h01);
    settle();
    chk8({7'h00, fast_osc_req}, 8'h01);
    fast_analog_ok = 1'b0;
    gwr(`MCS_OFS_SRC_CTRL, 8'h00);
    settle();
    rdc(`MCS_OFS_SRC_CTRL, 8'h00);
    fast_analog_ok = 1'b1;
    gwr(`MCS_OFS_FAST_FTRIM, 8'h0C);
    rdc(`MCS_OFS_FAST_FTRIM, 8'h0C);
    chk8({2'h0, fast_freq_trim}, 8'h0C);
    gwr(`MCS_OFS_LOCK, 8'h01);
    rdc(`MCS_OFS_LOCK, 8'h01);
    gwr(`MCS_OFS_PRE_CTRL, 8'h03);
    rdc(`MCS_OFS_PRE_CTRL, 8'h00);
    gwr(`MCS_OFS_FAST_FTRIM, 8'h21);
    rdc(`MCS_OFS_FAST_FTRIM, 8'h0C);
    // Second reset with the other center and the fuse lock set
    rst(1'b0, 1'b1);
    rdc(`MCS_OFS_LOCK, 8'h01);
    rdc(`MCS_OFS_PRE_CTRL, 8'h11);
    chk8({7'h00, fast_center_sel}, 8'h00);
    rdc(`MCS_OFS_FAST_TTRIM, {4'h8, temp_trim_16});
    gwr(`MCS_OFS_FAST_FTRIM, 8'h3F);
    rdc(`MCS_OFS_FAST_FTRIM, {2'h0, freq_trim_16});
    gwr(`MCS_OFS_PRE_CTRL, 8'h03);
    rdc(`MCS_OFS_PRE_CTRL, 8'h11);
    test_done();
  end
endmodule // test_mcs_top

bind mcs_top mcs_assertions mcs_assertions_i (
  .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .periph_pin_req(periph_pin_req),
  .pin_as_clock(pin_as_clock), .slow_osc_req(slow_osc_req), .main_en(main_en),
  .per_en(per_en), .tick_1k(tick_1k), .fast_center_sel(fast_center_sel),
  .fast_freq_trim(fast_freq_trim), .fast_temp_trim(fast_temp_trim)
);
